// File: hw/miu_top.sv
// Maskable interrupt unit: factor flags, masks, global enable, halt wake and vector fetch
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Timer tap falling edges set tap flags
// - Converter count reaching zero sets converter flag
// - Enabled input pin rise sets shared flag
// - Request needs flag, mask and global enable
// - Taking an interrupt clears global enable
// - Flags read-only, cleared by reading them
// - All flags zero after reset
// - Masks read-write, one enables, reset zero
// - Mask bits share flag bit positions
// - Unused register bits read as zero
// - Halt stops CPU clock, a pending masked flag wakes even with global enable clear
// - Vector fetch sequence lasts twelve clocks
module miu_top #(
   parameter int SEQ_LEN = miu_pkg::SEQ_CYCLES
) (
   // Clock, reset and enable
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         ce,
   // APB slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [miu_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [miu_pkg::DATA_W-1:0]   pwdata,
   output logic      [miu_pkg::DATA_W-1:0]   prdata,
   output logic                              pready,
   output logic                              pslverr,
   // Event sources
   input  wire miu_pkg::miu_src_t            src,
   // CPU core side
   output miu_pkg::miu_cpu_t                 cpu
);
   localparam logic [miu_pkg::SEQ_CNT_W-1:0] SEQ_LOAD = miu_pkg::SEQ_CNT_W'(SEQ_LEN);

   // Synchronised sources and their edges
   miu_pkg::miu_src_t           src_s;
   logic [miu_pkg::SRC_W-1:0]   src_rise;
   logic [miu_pkg::SRC_W-1:0]   src_fall;
   miu_pkg::miu_src_t           rise_s;
   miu_pkg::miu_src_t           fall_s;

   miu_sync #(.W(miu_pkg::SRC_W)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (src),
      .q       (src_s)
   );

   miu_edge #(.W(miu_pkg::SRC_W)) u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .lvl     (src_s),
      .rise    (src_rise),
      .fall    (src_fall)
   );

   assign rise_s = src_rise;
   assign fall_s = src_fall;

   // State
   logic [miu_pkg::TAP_COUNT-1:0] tap_flag_r;
   logic [miu_pkg::TAP_COUNT-1:0] tap_mask_r;
   logic                          conv_flag_r;
   logic                          conv_mask_r;
   logic                          input_flag_r;
   logic [miu_pkg::PIN_COUNT-1:0] pin_mask_r;
   logic                          ie_r;
   logic [miu_pkg::SEQ_CNT_W-1:0] seq_cnt_r;

   // Event decode
   logic [miu_pkg::TAP_COUNT-1:0] tap_evt;
   logic [miu_pkg::PIN_COUNT-1:0] pin_evt;
   logic                          conv_evt;
   logic                          input_evt;

   assign tap_evt[miu_pkg::BIT_TAP_SLOW] = fall_s.tap_slow;
   assign tap_evt[miu_pkg::BIT_TAP_MID]  = fall_s.tap_mid;
   assign tap_evt[miu_pkg::BIT_TAP_FAST] = fall_s.tap_fast;
   assign conv_evt  = rise_s.conv_zero;
   for (genvar i = 0; i < miu_pkg::PIN_COUNT; i++) begin : g_pin
      assign pin_evt[i] = rise_s.pins[i] & pin_mask_r[i];
   end
   assign input_evt = |pin_evt;

   // APB decode
   logic [miu_pkg::WORD_W-1:0] word;
   logic aligned, acc_first, acc_done, wr_done, rd_done;
   logic sel_pin_m, sel_tap_m, sel_conv_m, sel_in_f, sel_tap_f, sel_conv_f, sel_ctrl, sel_stat;
   logic hit;
   logic [miu_pkg::REG_W-1:0] rd_val;

   assign word      = paddr[miu_pkg::ADDR_W-1:2];
   assign aligned   = (paddr[1:0] == 2'h0);
   assign acc_first = psel & penable & ~pready;
   assign acc_done  = psel & penable & pready;
   assign wr_done   = acc_done & pwrite & ~pslverr;
   assign rd_done   = acc_done & ~pwrite & ~pslverr;

   assign sel_pin_m  = aligned & (word == miu_pkg::IDX_PIN_MASK);
   assign sel_tap_m  = aligned & (word == miu_pkg::IDX_TAP_MASK);
   assign sel_conv_m = aligned & (word == miu_pkg::IDX_CONV_MASK);
   assign sel_in_f   = aligned & (word == miu_pkg::IDX_INPUT_FLAG);
   assign sel_tap_f  = aligned & (word == miu_pkg::IDX_TAP_FLAG);
   assign sel_conv_f = aligned & (word == miu_pkg::IDX_CONV_FLAG);
   assign sel_ctrl   = aligned & (word == miu_pkg::IDX_CPU_CTRL);
   assign sel_stat   = aligned & (word == miu_pkg::IDX_CPU_STAT);
   assign hit = sel_pin_m | sel_tap_m | sel_conv_m | sel_in_f | sel_tap_f | sel_conv_f
              | sel_ctrl | sel_stat;

   // Read mux; unused positions stay zero
   assign rd_val = sel_pin_m  ? pin_mask_r
                 : sel_tap_m  ? {1'b0, tap_mask_r}
                 : sel_conv_m ? {3'h0, conv_mask_r}
                 : sel_in_f   ? {3'h0, input_flag_r}
                 : sel_tap_f  ? {1'b0, tap_flag_r}
                 : sel_conv_f ? {3'h0, conv_flag_r}
                 : sel_ctrl   ? {2'h0, ~cpu.run, ie_r}
                 : sel_stat   ? {cpu.req, cpu.busy, cpu.run, ie_r}
                 : miu_pkg::RD_ZERO;

   // Only bits that the answer actually showed as set are cleared
   logic [miu_pkg::TAP_COUNT-1:0] tap_clr;
   logic conv_clr, input_clr;
   assign tap_clr   = (rd_done & sel_tap_f) ? prdata[miu_pkg::TAP_COUNT-1:0] : '0;
   assign conv_clr  = rd_done & sel_conv_f & prdata[miu_pkg::BIT_CONV];
   assign input_clr = rd_done & sel_in_f & prdata[miu_pkg::BIT_INPUT];

   // Set wins over clear
   logic [miu_pkg::TAP_COUNT-1:0] tap_flag_nxt;
   logic conv_flag_nxt, input_flag_nxt;
   assign tap_flag_nxt   = (tap_flag_r & ~tap_clr) | tap_evt;
   assign conv_flag_nxt  = (conv_flag_r & ~conv_clr) | conv_evt;
   assign input_flag_nxt = (input_flag_r & ~input_clr) | input_evt;

   // Pending sources and request
   logic [miu_pkg::VEC_W-1:0] pend;
   logic any_pend, req_w, busy_w, take_w, halt_wr, ie_wr, ie_nxt, run_nxt;
   logic [miu_pkg::SEQ_CNT_W-1:0] seq_cnt_nxt;

   assign pend[miu_pkg::VEC_TIMER] = |(tap_flag_r & tap_mask_r);
   assign pend[miu_pkg::VEC_CONV]  = conv_flag_r & conv_mask_r;
   assign pend[miu_pkg::VEC_INPUT] = input_flag_r & (|pin_mask_r);
   assign any_pend = |pend;
   assign req_w    = any_pend & ie_r;
   assign busy_w   = (seq_cnt_r != '0);
   assign take_w   = req_w & ~busy_w & cpu.run;
   assign halt_wr  = wr_done & sel_ctrl & pwdata[miu_pkg::BIT_CTRL_HALT];
   assign ie_wr    = wr_done & sel_ctrl;
   assign ie_nxt   = take_w ? 1'b0
                   : ie_wr  ? pwdata[miu_pkg::BIT_CTRL_IE]
                   : ie_r;
   assign run_nxt  = any_pend ? 1'b1 : halt_wr ? 1'b0 : cpu.run;
   assign seq_cnt_nxt = take_w ? SEQ_LOAD
                      : busy_w ? seq_cnt_r - 1'b1
                      : seq_cnt_r;

   // Flags and masks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tap_flag_r   <= '0;
         conv_flag_r  <= 1'b0;
         input_flag_r <= 1'b0;
         tap_mask_r   <= '0;
         conv_mask_r  <= 1'b0;
         pin_mask_r   <= miu_pkg::RST_REG;
      end else if (ce) begin
         tap_flag_r   <= tap_flag_nxt;
         conv_flag_r  <= conv_flag_nxt;
         input_flag_r <= input_flag_nxt;
         if (wr_done && sel_pin_m)
            pin_mask_r <= pwdata[miu_pkg::REG_W-1:0];
         if (wr_done && sel_tap_m)
            tap_mask_r <= pwdata[miu_pkg::TAP_COUNT-1:0];
         if (wr_done && sel_conv_m)
            conv_mask_r <= pwdata[miu_pkg::BIT_CONV];
      end
   end

   // CPU side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie_r       <= 1'b0;
         seq_cnt_r  <= '0;
         cpu.req    <= 1'b0;
         cpu.take   <= 1'b0;
         cpu.run    <= 1'b1;
         cpu.busy   <= 1'b0;
         cpu.vector <= '0;
      end else if (ce) begin
         ie_r      <= ie_nxt;
         seq_cnt_r <= seq_cnt_nxt;
         cpu.req   <= req_w;
         cpu.take  <= take_w;
         cpu.run   <= run_nxt;
         cpu.busy  <= (seq_cnt_nxt != '0);
         if (take_w)
            cpu.vector <= pend;
      end
   end

   // APB answer: one wait state, then registered data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else if (ce) begin
         pready <= acc_first;
         if (acc_first) begin
            pslverr <= ~hit;
            prdata  <= {{(miu_pkg::DATA_W-miu_pkg::REG_W){1'b0}}, rd_val};
         end
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_take;
      ce && take_w;
   endsequence

   sequence s_fetch;
      $fell(cpu.busy);
   endsequence

   // Length of the current run of busy cycles, for the fetch length check
   localparam logic [miu_pkg::SEQ_CNT_W:0] BUSY_LEN = (miu_pkg::SEQ_CNT_W+1)'(SEQ_LEN);
   logic [miu_pkg::SEQ_CNT_W:0] busy_run_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         busy_run_r <= '0;
      else if (ce)
         busy_run_r <= cpu.busy ? busy_run_r + 1'b1 : '0;
   end

   tap_flag_set_a: assert property (
      ce && (|tap_evt) |=> (tap_flag_r & $past(tap_evt)) == $past(tap_evt))
      else $error("tap edge did not set its flag");
   tap_flag_hold_a: assert property (
      ce && !(|tap_evt) && tap_flag_r == '0 |=> tap_flag_r == '0)
      else $error("tap flag set without an edge");
   conv_flag_set_a: assert property (ce && conv_evt |=> conv_flag_r)
      else $error("converter zero did not set flag");
   conv_flag_hold_a: assert property (
      ce && !conv_evt && !conv_flag_r |=> !conv_flag_r)
      else $error("converter flag set without an event");
   input_flag_set_a: assert property (ce && input_evt |=> input_flag_r)
      else $error("enabled pin rise did not set flag");
   input_flag_hold_a: assert property (
      ce && !(|(rise_s.pins & pin_mask_r)) && !input_flag_r |=> !input_flag_r)
      else $error("input flag set without an enabled rise");
   req_gate_a: assert property (cpu.req |-> $past(ie_r) && $past(any_pend))
      else $error("request without enable or pending flag");
   ie_clear_a: assert property (s_take |=> !ie_r && cpu.take)
      else $error("global enable survived a taken interrupt");
   req_drop_a: assert property (s_take ##1 ce |=> !cpu.req)
      else $error("request stayed up after a taken interrupt");
   ie_write_a: assert property (
      ce && wr_done && sel_ctrl && !take_w |=> ie_r == $past(pwdata[miu_pkg::BIT_CTRL_IE]))
      else $error("global enable write not stored");
   read_clear_a: assert property (
      ce && rd_done && sel_conv_f && prdata[miu_pkg::BIT_CONV] && !conv_evt |=> !conv_flag_r)
      else $error("read did not clear converter flag");
   flag_write_ign_a: assert property (
      ce && wr_done |=> tap_flag_r == ($past(tap_flag_r) | $past(tap_evt)))
      else $error("write changed a tap flag");
   flag_other_rd_a: assert property (
      ce && rd_done && !sel_tap_f |=> tap_flag_r == ($past(tap_flag_r) | $past(tap_evt)))
      else $error("read of another register cleared a tap flag");
   mask_write_a: assert property (
      ce && wr_done && sel_pin_m |=> pin_mask_r == $past(pwdata[miu_pkg::REG_W-1:0]))
      else $error("pin mask write not stored");
   mask_hold_a: assert property (
      ce && !(wr_done && sel_pin_m) |=> pin_mask_r == $past(pin_mask_r))
      else $error("pin mask changed without a write");
   tap_mask_write_a: assert property (
      ce && wr_done && sel_tap_m |=> tap_mask_r == $past(pwdata[miu_pkg::TAP_COUNT-1:0]))
      else $error("tap mask write not stored in place");
   conv_mask_write_a: assert property (
      ce && wr_done && sel_conv_m |=> conv_mask_r == $past(pwdata[miu_pkg::BIT_CONV]))
      else $error("converter mask write not stored in place");
   reserved_zero_a: assert property (
      pready |-> prdata[miu_pkg::DATA_W-1:miu_pkg::REG_W] == '0)
      else $error("unused read bits not zero");
   tap_read_zero_a: assert property (
      ce && acc_first && (sel_tap_m || sel_tap_f) |=> !prdata[miu_pkg::REG_W-1])
      else $error("unused tap register bit not zero");
   halt_wake_a: assert property (ce && !cpu.run && any_pend |=> cpu.run)
      else $error("pending request did not wake from halt");
   halt_enter_a: assert property (ce && halt_wr && !any_pend |=> !cpu.run)
      else $error("halt write did not stop the core");
   busy_start_a: assert property (s_take |=> cpu.busy)
      else $error("vector fetch did not start");
   fetch_len_a: assert property (s_fetch |-> busy_run_r == BUSY_LEN)
      else $error("vector fetch length wrong");
   take_vec_a: assert property (cpu.take |-> cpu.vector != '0)
      else $error("taken interrupt without a source vector");
   vec_hold_a: assert property (
      ce && !take_w |=> cpu.vector == $past(cpu.vector))
      else $error("vector changed without a taken interrupt");
   set_wins_a: assert property (
      ce && tap_clr[miu_pkg::BIT_TAP_FAST] && tap_evt[miu_pkg::BIT_TAP_FAST]
      |=> tap_flag_r[miu_pkg::BIT_TAP_FAST])
      else $error("event lost in clearing cycle");
endmodule : miu_top

// File: common/miu_pkg.sv
// Constants, register indices and carrier types for the maskable interrupt unit
package miu_pkg;
   localparam int DATA_W    = 32;
   localparam int ADDR_W    = 12;
   localparam int WORD_W    = 10;
   localparam int REG_W     = 4;
   localparam int PIN_COUNT = 4;
   localparam int TAP_COUNT = 3;
   localparam int SRC_W     = 8;

   // Register indices; byte address is four times the index
   localparam logic [WORD_W-1:0] IDX_PIN_MASK   = 10'h0e8;
   localparam logic [WORD_W-1:0] IDX_TAP_MASK   = 10'h0eb;
   localparam logic [WORD_W-1:0] IDX_CONV_MASK  = 10'h0ec;
   localparam logic [WORD_W-1:0] IDX_INPUT_FLAG = 10'h0ed;
   localparam logic [WORD_W-1:0] IDX_TAP_FLAG   = 10'h0ef;
   localparam logic [WORD_W-1:0] IDX_CONV_FLAG  = 10'h0f0;
   localparam logic [WORD_W-1:0] IDX_CPU_CTRL   = 10'h0f2;
   localparam logic [WORD_W-1:0] IDX_CPU_STAT   = 10'h0f3;

   // Field positions
   localparam int BIT_TAP_FAST = 0;
   localparam int BIT_TAP_MID  = 1;
   localparam int BIT_TAP_SLOW = 2;
   localparam int BIT_CONV     = 0;
   localparam int BIT_INPUT    = 0;
   localparam int BIT_CTRL_IE   = 0;
   localparam int BIT_CTRL_HALT = 1;
   localparam int BIT_STAT_IE   = 0;
   localparam int BIT_STAT_RUN  = 1;
   localparam int BIT_STAT_BUSY = 2;
   localparam int BIT_STAT_REQ  = 3;
   localparam int VEC_TIMER = 0;
   localparam int VEC_CONV  = 1;
   localparam int VEC_INPUT = 2;
   localparam int VEC_W     = 3;

   // Reset values
   localparam logic [REG_W-1:0] RST_REG = 4'h0;
   localparam logic [REG_W-1:0] RD_ZERO = 4'h0;

   // Vector fetch sequence length in system clocks
   localparam int SEQ_CYCLES = 12;
   localparam int SEQ_CNT_W  = 4;

   typedef struct packed {
      logic                 tap_slow;
      logic                 tap_mid;
      logic                 tap_fast;
      logic                 conv_zero;
      logic [PIN_COUNT-1:0] pins;
   } miu_src_t;

   typedef struct packed {
      logic             req;
      logic             take;
      logic             run;
      logic             busy;
      logic [VEC_W-1:0] vector;
   } miu_cpu_t;
endpackage : miu_pkg

// File: hw/miu_sync.sv
// Two-stage synchroniser for a bus of independent levels
`timescale 1ns/1ps
module miu_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q      <= '0;
      end else if (ce) begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : miu_sync

// File: hw/miu_edge.sv
// Per-bit rise and fall detector on synchronised levels
`timescale 1ns/1ps
module miu_edge #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   // Levels and edges
   input  wire logic [W-1:0] lvl,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prev_r <= '0;
      else if (ce)
         prev_r <= lvl;
   end

   for (genvar i = 0; i < W; i++) begin : g_bit
      assign rise[i] = lvl[i] & ~prev_r[i];
      assign fall[i] = ~lvl[i] & prev_r[i];
   end
endmodule : miu_edge

// File: tb/miu_cpu_model.sv
// CPU core stand-in: counts accepted interrupts, keeps the vector, times the fetch
`timescale 1ns/1ps
module miu_cpu_model (
   // Clock and reset
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   // Core side of the unit
   input  wire miu_pkg::miu_cpu_t               cpu,
   // Observations
   output int                                   takes,
   output logic [miu_pkg::VEC_W-1:0]            last_vec,
   output int                                   fetch_len
);
   int cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         takes <= 0;
         last_vec <= 3'h0;
         fetch_len <= 0;
         cnt <= 0;
      end else begin
         if (cpu.take === 1'b1) begin
            takes <= takes + 1;
            last_vec <= cpu.vector;
         end
         // Fetch length is the run of busy cycles
         if (cpu.busy === 1'b1) begin
            cnt <= cnt + 1;
         end else if (cnt != 0) begin
            fetch_len <= cnt;
            cnt <= 0;
         end
      end
   end
endmodule : miu_cpu_model

// File: tb/miu_top_tb_top.sv
// Self-checking bench for the maskable interrupt unit
`timescale 1ns/1ps
module miu_top_tb_top;
   localparam int SEQ = miu_pkg::SEQ_CYCLES;
   logic                pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rerr;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, rdat;
   miu_pkg::miu_src_t   src;
   miu_pkg::miu_cpu_t   cpu;
   logic [2:0]          last_vec;
   int                  n_fail, n_checks, takes, fetch_len;

   miu_top #(.SEQ_LEN(SEQ)) miu_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src), .cpu(cpu));
   miu_cpu_model miu_cpu_model_inst (.pclk(pclk), .presetn(presetn), .cpu(cpu),
      .takes(takes), .last_vec(last_vec), .fetch_len(fetch_len));

   task automatic tally_and_finish();
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic expire(input int i);
      if (i >= 20) begin
         n_fail++;
         $display("ERROR %0t: wait timed out", $time);
         tally_and_finish();
      end
   endtask : expire

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      expire(i);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rdat, exp);
      chk({31'h0, rerr}, 32'h0);
   endtask : rd

   task automatic t_reset();
      rd(miu_pkg::IDX_PIN_MASK, 32'h0);
      rd(miu_pkg::IDX_TAP_MASK, 32'h0);
      rd(miu_pkg::IDX_CONV_MASK, 32'h0);
      rd(miu_pkg::IDX_INPUT_FLAG, 32'h0);
      rd(miu_pkg::IDX_TAP_FLAG, 32'h0);
      rd(miu_pkg::IDX_CONV_FLAG, 32'h0);
      apb(1'b0, 10'h0e9, 32'h0);
      chk({31'h0, rerr}, 32'h1);
   endtask : t_reset

   task automatic t_masks();
      apb(1'b1, miu_pkg::IDX_PIN_MASK, 32'hffff_ffff);
      rd(miu_pkg::IDX_PIN_MASK, 32'hf);
      apb(1'b1, miu_pkg::IDX_TAP_MASK, 32'hffff_ffff);
      rd(miu_pkg::IDX_TAP_MASK, 32'h7);
      apb(1'b1, miu_pkg::IDX_CONV_MASK, 32'hffff_ffff);
      rd(miu_pkg::IDX_CONV_MASK, 32'h1);
      apb(1'b1, miu_pkg::IDX_TAP_FLAG, 32'hffff_ffff);
      rd(miu_pkg::IDX_TAP_FLAG, 32'h0);
      apb(1'b1, miu_pkg::IDX_PIN_MASK, 32'h0);
      apb(1'b1, miu_pkg::IDX_TAP_MASK, 32'h0);
      apb(1'b1, miu_pkg::IDX_CONV_MASK, 32'h0);
      rd(miu_pkg::IDX_TAP_MASK, 32'h0);
   endtask : t_masks

   task automatic t_events();
      int b;
      for (b = 0; b < 3; b++) begin
         src[5+b] <= 1'b1;
         tick(6);
         rd(miu_pkg::IDX_TAP_FLAG, 32'h0);
         src[5+b] <= 1'b0;
         tick(6);
         rd(miu_pkg::IDX_TAP_FLAG, 32'h1 << b);
         rd(miu_pkg::IDX_TAP_FLAG, 32'h0);
      end
      src.conv_zero <= 1'b1;
      tick(6);
      rd(miu_pkg::IDX_CONV_FLAG, 32'h1);
      rd(miu_pkg::IDX_CONV_FLAG, 32'h0);
      src.conv_zero <= 1'b0;
      apb(1'b1, miu_pkg::IDX_PIN_MASK, 32'h4);
      src.pins <= 4'h2;
      tick(6);
      rd(miu_pkg::IDX_INPUT_FLAG, 32'h0);
      src.pins <= 4'h6;
      tick(6);
      rd(miu_pkg::IDX_INPUT_FLAG, 32'h1);
      src.pins <= 4'h0;
   endtask : t_events

   task automatic t_race();
      src.tap_fast <= 1'b1;
      tick(4);
      src.tap_fast <= 1'b0;
      tick(4);
      src.tap_fast <= 1'b1;
      tick(4);
      // Falling tap edge lands on the clearing edge of the read
      fork
         rd(miu_pkg::IDX_TAP_FLAG, 32'h1);
         begin
            tick(1);
            src.tap_fast <= 1'b0;
         end
      join
      rd(miu_pkg::IDX_TAP_FLAG, 32'h1);
      rd(miu_pkg::IDX_TAP_FLAG, 32'h0);
   endtask : t_race

   task automatic t_take();
      int i;
      apb(1'b1, miu_pkg::IDX_TAP_MASK, 32'h1);
      src.tap_fast <= 1'b1;
      tick(4);
      src.tap_fast <= 1'b0;
      tick(8);
      chk({31'h0, cpu.req}, 32'h0);
      apb(1'b1, miu_pkg::IDX_CPU_CTRL, 32'h1);
      tick(2);
      chk({31'h0, cpu.req}, 32'h1);
      chk({31'h0, cpu.take}, 32'h1);
      for (i = 0; i < 20 && takes == 0; i++) @(posedge pclk);
      expire(i);
      chk(last_vec, 32'h1);
      rd(miu_pkg::IDX_CPU_CTRL, 32'h0);
      tick(12);
      chk(fetch_len, SEQ);
      chk(takes, 1);
      rd(miu_pkg::IDX_TAP_FLAG, 32'h1);
      apb(1'b1, miu_pkg::IDX_TAP_MASK, 32'h0);
   endtask : t_take

   task automatic t_halt();
      int i;
      apb(1'b1, miu_pkg::IDX_CONV_MASK, 32'h1);
      apb(1'b1, miu_pkg::IDX_CPU_CTRL, 32'h2);
      tick(2);
      chk({31'h0, cpu.run}, 32'h0);
      src.conv_zero <= 1'b1;
      for (i = 0; i < 20 && cpu.run !== 1'b1; i++) @(posedge pclk);
      expire(i);
      chk({31'h0, cpu.run}, 32'h1);
      chk(takes, 1);
      rd(miu_pkg::IDX_CONV_FLAG, 32'h1);
      rd(miu_pkg::IDX_CPU_STAT, 32'h2);
   endtask : t_halt

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      src = '0;
      n_fail = 0;
      n_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_masks();
      t_events();
      t_race();
      t_take();
      t_halt();
      tally_and_finish();
   end
endmodule : miu_top_tb_top
